// >>> rtl/port_latch.sv
/*
 * one general-purpose parallel port: output latch, direction register,
 * cpu-side read, byte write and bit set or clear done as read-modify-write.
 * assumes the cpu side and the pin inputs are synchronous to clk_i; the
 * pin wire level is resolved outside from pin_o and pin_oe_n_o.
 */
`timescale 1ns/1ps
`include "port_latch_cfg.svh"
module port_latch
    import port_latch_pkg::*;
#(
    parameter int WIDTH = `PORT_WIDTH,
    parameter int IDX_W = `PORT_BIT_IDX_W,
    parameter logic [WIDTH-1:0] OPEN_DRAIN = `PORT_OD_MASK_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire port_cmd_t cmd_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [IDX_W-1:0] bit_idx_i,
    input wire logic rd_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] rdata_o,
    output logic busy_o,
    output logic [WIDTH-1:0] dir_o,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_n_o
);
    logic [WIDTH-1:0] latch_q;
    logic [WIDTH-1:0] dir_q;
    logic [WIDTH-1:0] snap_q;
    logic [IDX_W-1:0] idx_q;
    logic set_q;
    rmw_state_t state_q;
    logic [WIDTH-1:0] drive_mask;
    logic [WIDTH-1:0] idx_mask;

    // true for the two commands that run as read-modify-write
    function automatic logic is_bit_op(input port_cmd_t cmd);
        is_bit_op = (cmd == CMD_BIT_SET) || (cmd == CMD_BIT_CLEAR);
    endfunction

    // one-hot mask of the bit that a bit operation targets
    function automatic logic [WIDTH-1:0] bit_mask(
        input logic [IDX_W-1:0] idx
    );
        bit_mask = '0;
        bit_mask[idx] = 1'b1;
    endfunction

    // port read view: pins for input bits, latch for output bits
    function automatic logic [WIDTH-1:0] port_view(
        input logic [WIDTH-1:0] latch,
        input logic [WIDTH-1:0] dir,
        input logic [WIDTH-1:0] pins
    );
        port_view = (pins & ~dir) | (latch & dir);
    endfunction

    // read phase of a bit operation snapshots the whole byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            snap_q <= '0;
            idx_q <= '0;
            set_q <= 1'b0;
        end else if (state_q == ST_IDLE && is_bit_op(cmd_i)) begin
            state_q <= ST_MODIFY;
            snap_q <= port_view(latch_q, dir_q, pin_i);
            idx_q <= bit_idx_i;
            set_q <= (cmd_i == CMD_BIT_SET);
        end else begin
            state_q <= ST_IDLE;
        end
    end

    // latch: byte write or write back of the modified byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_q <= `PORT_LATCH_RESET;
        end else if (state_q == ST_MODIFY) begin
            latch_q <= snap_q;
            latch_q[idx_q] <= set_q;
        end else if (cmd_i == CMD_WRITE_DATA) begin
            latch_q <= wdata_i;
        end
    end

    // direction changes never touch the latch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir_q <= `PORT_DIR_RESET;
        end else if (state_q == ST_IDLE && cmd_i == CMD_WRITE_DIR) begin
            dir_q <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= '0;
            busy_o <= 1'b0;
            dir_o <= `PORT_DIR_RESET;
        end else begin
            if (rd_i) begin
                rdata_o <= port_view(latch_q, dir_q, pin_i);
            end
            busy_o <= (state_q == ST_IDLE) && is_bit_op(cmd_i);
            dir_o <= (state_q == ST_IDLE && cmd_i == CMD_WRITE_DIR) ?
                     wdata_i : dir_q;
        end
    end

    port_pin_cell #(
        .WIDTH(WIDTH)
    ) u_pins (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .latch_i(latch_q),
        .dir_out_i(dir_q),
        .open_drain_i(OPEN_DRAIN),
        .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o)
    );

    // masks used by the checks below
    assign drive_mask = dir_q & ~OPEN_DRAIN;
    assign idx_mask = bit_mask(idx_q);

    // a bit operation is accepted only while the read-modify-write is idle
    sequence bit_op_s;
        state_q == ST_IDLE && is_bit_op(cmd_i);
    endsequence

    // the write-back cycle that follows an accepted bit operation
    sequence modify_s;
        state_q == ST_MODIFY;
    endsequence

    // a direction write that is not refused
    sequence dir_write_s;
        state_q == ST_IDLE && cmd_i == CMD_WRITE_DIR;
    endsequence

    // a data write that no write-back overrides
    sequence data_write_s;
        state_q == ST_IDLE && cmd_i == CMD_WRITE_DATA;
    endsequence

    // read-modify-write checks
    rmw_writeback_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bit_op_s ##1 modify_s |=> latch_q[$past(idx_q)] == $past(set_q))
        else $error("bit operation result wrong");

    busy_pulse_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bit_op_s |=> busy_o ##1 !busy_o)
        else $error("busy not one cycle long");

    modify_once_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        modify_s |=> state_q == ST_IDLE)
        else $error("write-back lasted more than one cycle");

    // untargeted bits follow the byte read at the start of the operation
    input_bits_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bit_op_s ##1 modify_s |=>
            ((latch_q ^ $past(pin_i, 2)) & ~$past(dir_q, 2)
            & ~$past(idx_mask)) == '0)
        else $error("input bit not refreshed from pin");

    output_bits_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        bit_op_s ##1 modify_s |=>
            ((latch_q ^ $past(latch_q, 2)) & $past(dir_q, 2)
            & ~$past(idx_mask)) == '0)
        else $error("output bit not kept");

    // direction and latch checks
    dir_keeps_latch_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        dir_write_s |=> latch_q == $past(latch_q))
        else $error("direction write moved latch");

    dir_write_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        dir_write_s |=> dir_q == $past(wdata_i))
        else $error("direction write not stored");

    dir_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !(state_q == ST_IDLE && cmd_i == CMD_WRITE_DIR)
            |=> dir_q == $past(dir_q))
        else $error("direction changed without a write");

    data_write_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        data_write_s |=> latch_q == $past(wdata_i))
        else $error("data write not stored");

    // read path checks
    read_view_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        rd_i |=> rdata_o == (($past(pin_i) & ~$past(dir_q))
            | ($past(latch_q) & $past(dir_q))))
        else $error("read value wrong");

    rdata_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !rd_i |=> rdata_o == $past(rdata_o))
        else $error("read data changed without a read");

    // pin drive checks
    reset_input_a: assert property (@(posedge clk_i)
        rst_i |=> dir_q == `PORT_DIR_RESET && pin_oe_n_o == '1)
        else $error("port not input after reset");

    oe_safe_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        1'b1 |=> &(pin_oe_n_o | $past(dir_q)))
        else $error("input pin driven at the port");

    drive_follows_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        1'b1 |=> (pin_oe_n_o & $past(drive_mask)) == '0
            && ((pin_o ^ $past(latch_q)) & $past(drive_mask)) == '0)
        else $error("output pin not driven from latch");
endmodule

// >>> include/port_latch_cfg.svh
/*
 * constants for the parallel port latch block: widths, reset values and
 * the default open-drain mask for the port pins.
 * assumes it is included once per compile unit by its bare name.
 */
// Notes on behaviour
// - A pin whose direction bit selects input has its driver switched off so the pin floats.
// - An open-drain output pin is left undriven while its latch bit holds one, as if input.
// - Bit set and clear work as a whole-byte read, a one-bit change and a whole-byte write back.
// - A port read returns the live pin level for input bits, so read-modify-write stores it.
// - A port read returns the latch value for output bits, so read-modify-write rewrites it.
// - Turning a pin from output to input leaves its output latch unchanged.
// - An untargeted input bit of a bit operation still takes the pin level when it differs.
// - After reset every pin is input until software selects output.
`ifndef PORT_LATCH_CFG_SVH
`define PORT_LATCH_CFG_SVH

`define PORT_WIDTH 8
`define PORT_BIT_IDX_W 3
`define PORT_DIR_RESET 8'h00
`define PORT_LATCH_RESET 8'h00
`define PORT_OD_MASK_DEFAULT 8'h00

`endif

// >>> include/port_latch_pkg.sv
/*
 * types for the parallel port latch block.
 * assumes port_latch_cfg.svh is on the include path.
 */
package port_latch_pkg;
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_WRITE_DATA,
        CMD_WRITE_DIR,
        CMD_BIT_SET,
        CMD_BIT_CLEAR
    } port_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_MODIFY
    } rmw_state_t;
endpackage

// >>> rtl/port_pin_cell.sv
/*
 * pin driver stage for one port: turns latch, direction and open-drain
 * selection into per-pin output and active-low output enable.
 * assumes synchronous inputs; outputs are registered.
 */
`timescale 1ns/1ps
`include "port_latch_cfg.svh"
module port_pin_cell #(
    parameter int WIDTH = `PORT_WIDTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] latch_i,
    input wire logic [WIDTH-1:0] dir_out_i,
    input wire logic [WIDTH-1:0] open_drain_i,
    output logic [WIDTH-1:0] pin_o,
    output logic [WIDTH-1:0] pin_oe_n_o
);
    logic [WIDTH-1:0] drive;
    logic [WIDTH-1:0] od_one;
    logic [WIDTH-1:0] od_zero;

    // input bits float; open-drain bits holding one float too
    assign drive = dir_out_i & ~(open_drain_i & latch_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_oe_n_o <= '1;
            pin_o <= '0;
        end else begin
            pin_oe_n_o <= ~drive;
            pin_o <= latch_i & ~open_drain_i;
        end
    end

    // open-drain output bits split by latch value, for the checks below
    assign od_one = dir_out_i & open_drain_i & latch_i;
    assign od_zero = dir_out_i & open_drain_i & ~latch_i;

    float_input_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        1'b1 |=> &(pin_oe_n_o | $past(dir_out_i)))
        else $error("input pin driven");
    od_release_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        1'b1 |=> (~pin_oe_n_o & $past(od_one)) == '0)
        else $error("open-drain one driven");
    od_low_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        1'b1 |=> ((pin_oe_n_o | pin_o) & $past(od_zero)) == '0)
        else $error("open-drain zero not pulled low");
endmodule

// >>> tb/board_model.sv
/* board side of one port: pull-ups plus optional board drivers.
   assumes pin output enables from the port are active low. */
`timescale 1ns/1ps
module board_model (
    input wire logic [7:0] drv_val_i,
    input wire logic [7:0] oe_n_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_lvl_o
);
    // released lines float to the pull-up unless the board drives them
    assign pin_lvl_o = (~oe_n_i & drv_val_i)
        | (oe_n_i & ((ext_en_i & ext_val_i) | ~ext_en_i));
endmodule

// >>> tb/testbench.sv
/* random and corner tests of one port with an open-drain upper nibble.
   assumes board_model resolves the pin levels. */
`timescale 1ns/1ps
module testbench;
import port_latch_pkg::*;
localparam logic [7:0] OD = 8'hf0;
logic clk_i = 1'h0;
logic rst_i = 1'h1;
logic rd_i = 1'h0;
logic busy_o;
logic [2:0] bit_idx_i = 3'h0;
logic [7:0] wdata_i = 8'h00;
logic [7:0] ext_en = 8'h00;
logic [7:0] ext_val = 8'h00;
logic [7:0] exp_lat = 8'h00;
logic [7:0] exp_dir = 8'h00;
logic [7:0] pin_i, rdata_o, dir_o, pin_o, pin_oe_n_o;
logic [31:0] rnd = 32'h0fd674c8;
port_cmd_t cmd_i = CMD_NONE;
int n_mismatch = 0;
int check_count = 0;
int cycles = 0;

always #10 clk_i = ~clk_i;

port_latch #(.OPEN_DRAIN(OD)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_i(cmd_i), .wdata_i(wdata_i), .bit_idx_i(bit_idx_i), .rd_i(rd_i),
    .pin_i(pin_i), .rdata_o(rdata_o), .busy_o(busy_o), .dir_o(dir_o),
    .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o));
board_model board (.drv_val_i(pin_o), .oe_n_i(pin_oe_n_o),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_lvl_o(pin_i));

function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
endfunction

// output bits read back the latch, input bits the board level
function automatic logic [7:0] rd_exp(input logic [7:0] lat, dir);
    return (dir & lat) | (~dir & ((ext_en & ext_val) | ~ext_en));
endfunction

task automatic chk(input logic [7:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
        n_mismatch++;
        $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
endtask

task automatic op(input port_cmd_t c, input logic [7:0] d,
    input logic [2:0] k);
    @(negedge clk_i);
    cmd_i = c;
    wdata_i = d;
    bit_idx_i = k;
    @(negedge clk_i);
    cmd_i = CMD_NONE;
    chk(8'(busy_o), 8'(c >= CMD_BIT_SET), "busy");
    repeat (3) @(negedge clk_i);
    case (c)
        CMD_WRITE_DATA: exp_lat = d;
        CMD_WRITE_DIR: exp_dir = d;
        default: begin
            exp_lat = rd_exp(exp_lat, exp_dir);
            exp_lat[k] = (c == CMD_BIT_SET);
        end
    endcase
endtask

task automatic check_all();
    @(negedge clk_i);
    rd_i = 1'h1;
    @(negedge clk_i);
    rd_i = 1'h0;
    chk(rdata_o, rd_exp(exp_lat, exp_dir), "read");
    chk(dir_o, exp_dir, "dir");
    chk(pin_oe_n_o, ~exp_dir | (OD & exp_lat), "oe");
    chk(pin_o & exp_dir & ~OD, exp_lat & exp_dir & ~OD, "pin");
    chk(8'(busy_o), 8'h00, "idle");
endtask

task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
        $display("bench passed");
    end else begin
        $display("bench failed");
    end
    $finish;
endtask

always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
        n_mismatch++;
        $display("mismatch at %0t: timeout", $time);
        report_and_stop();
    end
end

initial begin
    repeat (8) @(negedge clk_i);
    rst_i = 1'h0;
    check_all();
    op(CMD_WRITE_DATA, 8'h5a, 3'h0);
    op(CMD_WRITE_DIR, 8'hff, 3'h0);
    check_all();
    op(CMD_WRITE_DIR, 8'h00, 3'h0);
    op(CMD_WRITE_DIR, 8'hff, 3'h0);
    check_all();
    $display("test corner done");
    @(negedge clk_i);
    rst_i = 1'h1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'h0;
    exp_lat = 8'h00;
    exp_dir = 8'h00;
    check_all();
    op(CMD_WRITE_DIR, 8'hff, 3'h0);
    check_all();
    $display("test reset done");
    repeat (300) begin
        rnd = lfsr(rnd);
        ext_en = rnd[7:0];
        ext_val = rnd[15:8];
        op(port_cmd_t'({1'b0, rnd[17:16]} + 3'h1), rnd[31:24], rnd[21:19]);
        check_all();
    end
    $display("test random done");
    report_and_stop();
end
endmodule
